//--- rtl/printer_port_gpib_status_regs.sv
// Printer port data and status registers for an instrument bus bridge.
// Assumes host I/O strobes are one-cycle pulses already on CLK_SYS, and
// that a source handshake engine drains SRC_* and owns the bus wires.
`timescale 1ns/10ps

module printer_port_gpib_status_regs
   import lpt_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET,
   // Host I/O access
   input wire logic [9:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [7:0] IO_WDATA,
   output logic [7:0] IO_RDATA,
   output logic IO_RVALID,
   // Board jumpers and switches
   input wire logic [1:0] BASE_SEL,
   input wire logic [4:0] LISTEN_ADDR_SW,
   input wire logic SERVICE_REQUEST_OPTION,
   // Control register signals
   input wire logic STROBE_IN,
   input wire logic IRQ_ENABLE_BIT,
   output logic IRQ_OUT,
   // Instrument bus lines, active low
   input wire logic NRFD_N,
   input wire logic NDAC_N,
   input wire logic ATN_N,
   input wire logic SRQ_N,
   // Byte stream to the source handshake engine
   output logic SRC_VALID,
   input wire logic SRC_READY,
   output logic [7:0] SRC_DATA,
   output logic SRC_ATN
);
   localparam int AW = $clog2(ACK_CYC + 1);
   localparam logic [AW-1:0] ACK_LOAD = AW'(ACK_CYC);
   localparam logic [AW-1:0] ACK_ONE = AW'(1);
   localparam int WW = $bits(bus_word_t);

   // Host side registers
   logic [7:0] data_r;                // Output byte latch
   logic [7:0] rdata_r;               // Read answer
   logic rvalid_r;                    // Read answer valid
   // Synchroniser stages for the bus lines
   bus_lines_t meta_r;                // First stage, read only by sync_r
   bus_lines_t sync_r;                // Stable copy
   logic ndac_prev_r;                 // Last stable NDAC, for edge finding
   // Acknowledge pulse timer
   logic [AW-1:0] ack_cnt_r;
   logic irq_r;
   // Byte feeder
   feed_state_t state_r;
   feed_state_t state_nxt;
   logic [7:0] pend_r;                // Secondary latch of the strobed byte
   logic addressed_r;                 // Listener already addressed
   logic strobe_prev_r;
   // Output stage
   bus_word_t out_r;
   logic out_valid_r;

   // Decode and status wires
   logic [9:0] base_w;
   logic page_hit;
   logic hit_data;
   logic hit_stat;
   logic strobe_rise;
   logic ndac_rel;
   logic ack_active;
   logic ack_ending;
   logic busy;
   logic paper;
   logic [7:0] stat_w;
   logic push_w;
   bus_word_t push_word;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [WW-1:0] fifo_out_data;
   bus_word_t fifo_word;

   // Base address follows the jumpers; unused code falls back to port 2
   assign base_w = (BASE_SEL == BASE_SEL_MDA) ? BASE_MDA :
                   (BASE_SEL == BASE_SEL_PA1) ? BASE_PA1 : BASE_PA2;

   // All bases are word aligned, so the low two bits pick the register
   assign page_hit = (IO_ADDR[9:2] == base_w[9:2]);
   assign hit_data = page_hit & (IO_ADDR[1:0] == OFF_OUTPUT_BYTE);
   assign hit_stat = page_hit & (IO_ADDR[1:0] == OFF_PRINTER_STATUS);

   // Output byte latch; a status write has no decode, so it is dropped
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         data_r <= OUTPUT_BYTE_RESET;
      end else if (IO_WR && hit_data) begin
         data_r <= IO_WDATA;
      end
   end

   // Read answer, registered one cycle after the read strobe
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= IO_RD & (hit_data | hit_stat);
         if (IO_RD && hit_data) begin
            rdata_r <= data_r;
         end else if (IO_RD && hit_stat) begin
            rdata_r <= stat_w;
         end
      end
   end

   // Two-stage synchroniser; the lines are inverted to asserted-high
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         meta_r <= '0;
         sync_r <= '0;
         ndac_prev_r <= 1'b0;
      end else begin
         meta_r <= '{nrfd: ~NRFD_N, ndac: ~NDAC_N, atn: ~ATN_N,
                     srq: ~SRQ_N};
         sync_r <= meta_r;
         ndac_prev_r <= sync_r.ndac;
      end
   end

   // NDAC going unasserted means the listener took the byte
   assign ndac_rel = ndac_prev_r & ~sync_r.ndac;
   assign ack_active = (ack_cnt_r != '0);
   assign ack_ending = (ack_cnt_r == ACK_ONE) & ~ndac_rel;

   // Pulse timer; a new release restarts it so the pulse never shortens
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ack_cnt_r <= '0;
      end else if (ndac_rel) begin
         ack_cnt_r <= ACK_LOAD;
      end else if (ack_active) begin
         ack_cnt_r <= ack_cnt_r - 1'b1;
      end
   end

   // Interrupt pulse in the cycle the acknowledge goes inactive
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= IRQ_ENABLE_BIT & ack_ending;
      end
   end

   // Busy while a byte is in flight, the queue is full or NRFD holds off
   assign busy = sync_r.nrfd | (state_r != ST_IDLE) | ~fifo_in_ready;
   assign paper = SERVICE_REQUEST_OPTION & sync_r.srq;

   // Status image; low three bits are free and read as zero
   assign stat_w = {~busy, ~ack_active, paper, ~sync_r.atn,
                    1'b1, 3'b000};

   // Strobe edge copies the output byte into the secondary latch
   assign strobe_rise = STROBE_IN & ~strobe_prev_r;

   // Feeder pushes the listen command first while not yet addressed, then the byte itself
   assign push_w = (state_r != ST_IDLE) & fifo_in_ready;
   assign push_word = (state_r == ST_ADDR) ?
      bus_word_t'{1'b1, LISTEN_CMD_BASE | {3'h0, LISTEN_ADDR_SW}} :
      bus_word_t'{1'b0, pend_r};

   // Feeder next state; strobes while not idle are ignored, busy shows it
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (strobe_rise) begin
               state_nxt = addressed_r ? ST_DATA : ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (fifo_in_ready) begin
               state_nxt = ST_DATA;
            end
         end
         ST_DATA: begin
            if (fifo_in_ready) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Feeder registers
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state_r <= ST_IDLE;
         pend_r <= 8'h00;
         addressed_r <= 1'b0;
         strobe_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         strobe_prev_r <= STROBE_IN;
         if (state_r == ST_IDLE && strobe_rise) begin
            pend_r <= data_r;
         end
         if (state_r == ST_ADDR && fifo_in_ready) begin
            addressed_r <= 1'b1;
         end
      end
   end

   // Queue between the feeder and the handshake engine
   word_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK_SYS),
      .reset(RESET),
      .in_valid(push_w),
      .in_ready(fifo_in_ready),
      .in_data(push_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // Output register keeps SRC_* glitch free; it stalls with SRC_READY
   assign fifo_word = bus_word_t'(fifo_out_data);
   assign fifo_out_ready = ~out_valid_r | SRC_READY;

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         out_r <= '0;
         out_valid_r <= 1'b0;
      end else if (fifo_out_ready) begin
         out_valid_r <= fifo_out_valid;
         if (fifo_out_valid) begin
            out_r <= fifo_word;
         end
      end
   end

   // Ports
   assign IO_RDATA = rdata_r;
   assign IO_RVALID = rvalid_r;
   assign IRQ_OUT = irq_r;
   assign SRC_VALID = out_valid_r;
   assign SRC_DATA = out_r.data;
   assign SRC_ATN = out_r.atn;

   // Helper: length of the current acknowledge pulse
   logic [AW:0] ack_len_r;
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ack_len_r <= '0;
      end else begin
         ack_len_r <= ack_active ? ack_len_r + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);

   a_data_store:
   assert property (IO_WR && hit_data |=> data_r == $past(IO_WDATA))
      else $error("Output byte not stored on write");

   a_data_read:
   assert property (IO_RD && hit_data && !IO_WR
                    |=> IO_RVALID && IO_RDATA == data_r)
      else $error("Output byte read back wrong");

   a_stat_ro:
   assert property (IO_WR && hit_stat |=> $stable(data_r))
      else $error("Status write disturbed a register");

   a_busy_nrfd:
   assert property (sync_r.nrfd |-> !stat_w[STAT_BUSY_N_BIT])
      else $error("Busy not shown while NRFD held");

   a_ack_start:
   assert property (ndac_rel |=> !stat_w[STAT_ACK_N_BIT] [*8])
      else $error("Acknowledge did not start on NDAC release");

   a_ack_width:
   assert property ($rose(stat_w[STAT_ACK_N_BIT]) |->
                    ack_len_r >= (AW+1)'(ACK_CYC))
      else $error("Acknowledge pulse too short");

   a_paper_srq:
   assert property (SERVICE_REQUEST_OPTION |->
                    stat_w[STAT_PAPER_BIT] == sync_r.srq)
      else $error("Paper bit does not follow SRQ");

   a_paper_off:
   assert property (!SERVICE_REQUEST_OPTION |-> !stat_w[STAT_PAPER_BIT])
      else $error("Paper bit set with option off");

   a_select_atn:
   assert property (stat_w[STAT_SELECT_BIT] == !$past(~ATN_N, 2))
      else $error("Select bit does not track ATN");

   a_listen_first:
   assert property (state_r == ST_IDLE && strobe_rise && !addressed_r
      |=> push_word.atn && push_word.data ==
          (LISTEN_CMD_BASE | {3'h0, $past(LISTEN_ADDR_SW)}))
      else $error("First byte not preceded by listen address");

   a_err_high:
   assert property (IO_RD && hit_stat |=> IO_RDATA[STAT_ERROR_N_BIT])
      else $error("Error bit read low");

   a_irq_ack:
   assert property (IRQ_OUT |-> !ack_active && $past(ack_active)
                    && $past(IRQ_ENABLE_BIT))
      else $error("Interrupt not tied to acknowledge end");

   a_sync_delay:
   assert property ($fell(SRQ_N) && SERVICE_REQUEST_OPTION ##1
                    SERVICE_REQUEST_OPTION && !SRQ_N
                    |=> stat_w[STAT_PAPER_BIT])
      else $error("SRQ not seen two cycles after pin");

endmodule

//--- rtl/lpt_pkg.sv
// Shared constants and types for the printer port status block.
// Assumes a single 100 MHz system clock; all counts are derived here.
package lpt_pkg;

   // Jumper choices for the base I/O address
   localparam logic [1:0] BASE_SEL_PA2 = 2'h0;
   localparam logic [1:0] BASE_SEL_PA1 = 2'h1;
   localparam logic [1:0] BASE_SEL_MDA = 2'h2;
   localparam logic [9:0] BASE_PA2 = 10'h278;
   localparam logic [9:0] BASE_PA1 = 10'h378;
   localparam logic [9:0] BASE_MDA = 10'h3BC;

   // Register offsets from the base address
   localparam logic [1:0] OFF_OUTPUT_BYTE = 2'h0;
   localparam logic [1:0] OFF_PRINTER_STATUS = 2'h1;

   // Status register field positions
   localparam int STAT_BUSY_N_BIT = 7;
   localparam int STAT_ACK_N_BIT = 6;
   localparam int STAT_PAPER_BIT = 5;
   localparam int STAT_SELECT_BIT = 4;
   localparam int STAT_ERROR_N_BIT = 3;

   // Reset values
   localparam logic [7:0] OUTPUT_BYTE_RESET = 8'h00;

   // Listen address command is this base ORed with the switch address
   localparam logic [7:0] LISTEN_CMD_BASE = 8'h20;

   // Timing: acknowledge pulse is a least time, so round up
   localparam int CLK_PERIOD_NS = 10;
   localparam int ACK_PULSE_NS = 5000;
   localparam int ACK_CYC = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Depth of the outgoing byte queue
   localparam int FIFO_DEPTH = 4;

   // One byte for the instrument bus, with its attention flag
   typedef struct packed {
      logic atn;
      logic [7:0] data;
   } bus_word_t;

   // Instrument bus lines, asserted high after inversion
   typedef struct packed {
      logic nrfd;
      logic ndac;
      logic atn;
      logic srq;
   } bus_lines_t;

   // Byte feeder states, Gray coded along idle -> address -> data
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b11
   } feed_state_t;

endpackage

//--- rtl/word_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];   // Storage words
   logic [PW-1:0] wr_ptr_r;           // Next slot to fill
   logic [PW-1:0] rd_ptr_r;           // Oldest slot
   logic [CW-1:0] cnt_r;              // Words held
   logic do_wr;
   logic do_rd;

   // Full and empty come straight from the count
   assign in_ready = (cnt_r != FULL_CNT);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_ptr_r];
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;

   // Pointers and count; wrap explicitly so depth need not be a power of 2
   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   // Storage needs no reset; empty slots are never shown
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

endmodule

//--- test/host_model.sv
// Host processor model that runs I/O cycles against the port block.
// Assumes answers come within a few cycles of the read strobe edge.
`timescale 1ns/10ps
module host_model (
   // Clock
   input wire logic clk,
   // I/O cycle signals
   output logic [9:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rvalid
);
   // Idle bus from time zero
   initial begin
      io_addr = 10'h000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end

   // One-cycle write; released lines flip so stale values never match
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge clk) #1;
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask

   // One-cycle read; answer looked for over a short bounded window
   task automatic rd(input logic [9:0] a, output logic [7:0] d,
                     output logic ok);
      int n;
      @(posedge clk) #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge clk) #1;
      io_rd = 1'b0;
      io_addr = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 3 && !ok; n++) begin
         if (io_rvalid === 1'b1) begin
            ok = 1'b1;
            d = io_rdata;
         end else begin
            @(posedge clk) #1;
         end
      end
   endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the printer port data and status block.
// Assumes the host model above and a bench-driven instrument bus.
`timescale 1ns/10ps
module tb_top;
   import lpt_pkg::*;
   // Clock, reset and block signals
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [9:0] io_addr;
   logic io_wr, io_rd, io_rvalid, src_valid, src_atn, irq;
   logic [7:0] io_wdata, io_rdata, src_data;
   logic [1:0] base_sel = 2'h0;
   logic [4:0] sw = 5'h06;
   logic opt = 1'b1, strobe = 1'b0, irq_en = 1'b0, src_ready = 1'b1;
   logic nrfd_n = 1'b1, ndac_n = 1'b1, atn_n = 1'b1, srq_n = 1'b1;
   // Result bookkeeping
   int fails = 0, checked = 0, irqs = 0;
   bus_word_t q[$];

   always #5 clk_sys = ~clk_sys;

   host_model host (.clk(clk_sys), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid));

   printer_port_gpib_status_regs DUT (.CLK_SYS(clk_sys), .RESET(reset),
      .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
      .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid),
      .BASE_SEL(base_sel), .LISTEN_ADDR_SW(sw),
      .SERVICE_REQUEST_OPTION(opt), .STROBE_IN(strobe),
      .IRQ_ENABLE_BIT(irq_en), .IRQ_OUT(irq), .NRFD_N(nrfd_n),
      .NDAC_N(ndac_n), .ATN_N(atn_n), .SRQ_N(srq_n),
      .SRC_VALID(src_valid), .SRC_READY(src_ready),
      .SRC_DATA(src_data), .SRC_ATN(src_atn));

   // Collect every word the handshake engine takes, and count interrupts
   always @(posedge clk_sys) begin
      if (src_valid === 1'b1 && src_ready === 1'b1)
         q.push_back('{atn: src_atn, data: src_data});
      if (irq === 1'b1)
         irqs++;
   end

   task automatic final_report;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Byte or bus word compare, four-state exact
   task automatic chkv(string nm, logic [8:0] e, logic [8:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Count compare
   task automatic chkn(string nm, int e, int g);
      checked++;
      if (g != e) begin
         fails++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   task automatic step(int n);
      repeat (n) @(posedge clk_sys) #1;
   endtask

   // Status read; low three bits are free, so masked off
   task automatic stat(string nm, logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.rd(BASE_PA2 + 10'h001, d, ok);
      chkv(nm, {1'b1, e & 8'hF8}, {ok, d & 8'hF8});
   endtask

   task automatic rd_data(string nm, logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.rd(BASE_PA2, d, ok);
      chkv(nm, {1'b1, e}, {ok, d});
   endtask

   // Rising strobe after loading the data register
   task automatic send(logic [7:0] b);
      host.wr(BASE_PA2, b);
      strobe = 1'b1;
      step(1);
      strobe = 1'b0;
      step(3);
   endtask

   // Bounded wait on the collected words; running out ends the run
   task automatic waitq(int n);
      int k;
      for (k = 0; k < 300 && q.size() < n; k++)
         step(1);
      if (q.size() < n) begin
         chkn("words_timeout", n, q.size());
         final_report();
      end
   endtask

   task automatic t_data;
      logic [7:0] d;
      logic ok;
      rd_data("data_reset", OUTPUT_BYTE_RESET);
      host.wr(BASE_PA2, 8'hA5);
      rd_data("data_rw", 8'hA5);
      rd_data("data_reread", 8'hA5);
      host.wr(BASE_PA2 + 10'h002, 8'h3C);
      host.wr(BASE_PA2 + 10'h001, 8'h00);
      rd_data("data_kept", 8'hA5);
      stat("status_ro", 8'hD8);
      host.rd(BASE_PA2 + 10'h002, d, ok);
      chkv("unmapped_ans", 9'h000, {8'h00, ok});
   endtask

   // Each bus line and the option switch seen in the status byte;
   // pattern bits are option, NDAC, ATN, SRQ, NRFD (NDAC stays released)
   task automatic t_status;
      logic [4:0] tc[5] = '{5'h0F, 5'h1D, 5'h0D, 5'h1B, 5'h1E};
      logic [7:0] te[5] = '{8'hD8, 8'hF8, 8'hD8, 8'hC8, 8'h58};
      int i;
      for (i = 0; i < 5; i++) begin
         {opt, ndac_n, atn_n, srq_n, nrfd_n} = tc[i];
         step(4);
         stat("status_lines", te[i]);
      end
      {opt, ndac_n, atn_n, srq_n, nrfd_n} = 5'h1F;
      step(4);
   endtask

   task automatic t_base;
      logic [7:0] d;
      logic ok;
      base_sel = BASE_SEL_PA1;
      host.wr(BASE_PA1, 8'h5A);
      host.rd(BASE_PA1, d, ok);
      chkv("base_alt", 9'h15A, {ok, d});
      host.rd(BASE_PA2, d, ok);
      chkv("base_old", 9'h000, {8'h00, ok});
      base_sel = BASE_SEL_PA2;
   endtask

   // First byte brings a listen address; far side stalls meanwhile
   task automatic t_stream;
      src_ready = 1'b0;
      send(8'h41);
      step(8);
      chkv("stall_hold", {1'b1, LISTEN_CMD_BASE | 8'h06},
           {src_atn, src_data});
      src_ready = 1'b1;
      waitq(2);
      chkv("listen_word", {1'b1, LISTEN_CMD_BASE | 8'h06}, q[0]);
      chkv("first_byte", 9'h041, q[1]);
      send(8'h42);
      waitq(3);
      step(5);
      chkn("no_readdress", 3, q.size());
      chkv("second_byte", 9'h042, q[2]);
   endtask

   // Fill the queue until busy shows, then drain in order
   task automatic t_fill;
      logic [7:0] d;
      logic ok;
      int n, sent, base;
      src_ready = 1'b0;
      sent = 0;
      base = q.size();
      for (n = 0; n < 8; n++) begin
         host.rd(BASE_PA2 + 10'h001, d, ok);
         if (d[STAT_BUSY_N_BIT] === 1'b1) begin
            send(8'h60 + 8'(sent));
            sent++;
         end
      end
      stat("busy_full", 8'h58);
      chkn("accepted", 1, int'(sent >= FIFO_DEPTH));
      src_ready = 1'b1;
      waitq(base + sent);
      for (n = 0; n < sent; n++)
         chkv("drain", {1'b0, 8'h60 + 8'(n)}, q[base + n]);
   endtask

   // Acknowledge pulse length and interrupt as it ends
   task automatic t_ack(logic en, int e);
      irq_en = en;
      irqs = 0;
      ndac_n = 1'b0;
      step(4);
      ndac_n = 1'b1;
      step(20);
      stat("ack_start", 8'h98);
      step(460);
      stat("ack_still", 8'h98);
      step(40);
      stat("ack_end", 8'hD8);
      chkn("irq_count", e, irqs);
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      #1 reset = 1'b0;
      t_data();
      t_status();
      t_base();
      t_stream();
      t_fill();
      t_ack(1'b1, 1);
      t_ack(1'b0, 0);
      final_report();
   end
endmodule
